// ### hw/slpc_top.v
// Latch file and power-down control behind the 3-wire serial port.
// Assumes serial clock, data, strobe, chip enable and reference output are asynchronous pins.
`timescale 1ns/100ps
`default_nettype none
`include "slpc_consts.vh"
module slpc_top (
    input wire ref_clk_i,              // 125 MHz system clock
    input wire rstn_i,                 // Synchronous reset, active low
    input wire serial_clk_i,           // Serial clock pin
    input wire serial_data_i,          // Serial data pin
    input wire latch_load_strobe_i,    // Latch load strobe pin
    input wire chip_enable_i,          // Chip enable pin, high = enabled
    input wire ref_div_out_i,          // Reference divider output
    output reg [23:0] control_latch_o, // General control latch
    output reg [23:0] fb_latch_o,      // Feedback divider latch
    output reg [23:0] ref_latch_o,     // Reference divider latch
    output reg [1:0] prescale_sel_o,   // Prescaler select
    output reg [12:0] main_count_o,    // Main counter value
    output reg [4:0] swallow_count_o,  // Swallow counter value
    output reg [13:0] ref_div_o,       // Reference ratio
    output reg pump_gain_bit_o,        // Effective pump gain
    output reg powered_down_o,         // Device in power-down
    output reg counters_load_o,        // Counters held in load state
    output reg pump_tristate_o,        // Charge pump three-state
    output reg lock_detect_reset_o,    // Digital lock detector reset
    output reg rf_debias_o,            // RF outputs high impedance
    output reg ref_buffer_off_o,       // Reference buffer disabled
    output reg dc_paths_off_o          // Active DC paths removed
);
    localparam PD_ON = 2'h0;
    localparam PD_WAIT = 2'h1;
    localparam PD_DOWN = 2'h2;

    wire sclk_s;
    wire sdata_s;
    wire strobe_s;
    wire ce_s;
    wire refo_s;
    reg sclk_d_reg;
    reg strobe_d_reg;
    reg refo_d_reg;
    reg [23:0] shift_reg;
    reg [1:0] pd_state_reg;
    reg [1:0] edge_cnt_reg;
    reg pump_gain_reg;
    reg [1:0] pd_state_next;
    wire sclk_rise;
    wire strobe_rise;
    wire refo_rise;
    wire pd_req;
    wire pd_sync;
    wire down;

    // Pins share one synchroniser shape; data sampled as late as the clock so order holds
    slpc_sync3 u_sclk (.clk_i(ref_clk_i), .rstn_i(rstn_i), .pin_i(serial_clk_i), .level_o(sclk_s));
    slpc_sync3 u_sdat (.clk_i(ref_clk_i), .rstn_i(rstn_i), .pin_i(serial_data_i), .level_o(sdata_s));
    slpc_sync3 u_strb (.clk_i(ref_clk_i), .rstn_i(rstn_i), .pin_i(latch_load_strobe_i), .level_o(strobe_s));
    slpc_sync3 u_ce (.clk_i(ref_clk_i), .rstn_i(rstn_i), .pin_i(chip_enable_i), .level_o(ce_s));
    slpc_sync3 u_refo (.clk_i(ref_clk_i), .rstn_i(rstn_i), .pin_i(ref_div_out_i), .level_o(refo_s));

    // Edge detection on filtered levels
    assign sclk_rise = sclk_s & ~sclk_d_reg;
    assign strobe_rise = strobe_s & ~strobe_d_reg;
    assign refo_rise = refo_s & ~refo_d_reg;
    assign pd_req = control_latch_o[`SLPC_CTL_PD_REQ];
    assign pd_sync = control_latch_o[`SLPC_CTL_PD_SYNC];

    always @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            sclk_d_reg <= 1'b0;
            strobe_d_reg <= 1'b0;
            refo_d_reg <= 1'b0;
            shift_reg <= `SLPC_LATCH_RESET;
        end else begin
            sclk_d_reg <= sclk_s;
            strobe_d_reg <= strobe_s;
            refo_d_reg <= refo_s;
            if (sclk_rise) begin
                shift_reg <= {shift_reg[22:0], sdata_s};
            end
        end
    end

    // Latches written only by strobe, never by power-down
    // Test-latch code is accepted and dropped; the factory latch is not kept
    always @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            control_latch_o <= `SLPC_LATCH_RESET;
            fb_latch_o <= `SLPC_LATCH_RESET;
            ref_latch_o <= `SLPC_LATCH_RESET;
            pump_gain_reg <= 1'b0;
        end else if (strobe_rise) begin
            case (shift_reg[1:0])
                `SLPC_SEL_CONTROL: begin
                    control_latch_o <= shift_reg;
                    pump_gain_reg <= shift_reg[`SLPC_CTL_PUMP_GAIN];
                end
                `SLPC_SEL_REFDIV: begin
                    ref_latch_o <= shift_reg;
                end
                `SLPC_SEL_FBDIV: begin
                    fb_latch_o <= shift_reg;
                    pump_gain_reg <= shift_reg[`SLPC_FB_PUMP_GAIN];
                end
                default: begin
                end
            endcase
        end
    end

    // Power-down state machine
    always @* begin
        pd_state_next = pd_state_reg;
        case (pd_state_reg)
            PD_ON: begin
                if (strobe_rise && shift_reg[1:0] == `SLPC_SEL_CONTROL && shift_reg[`SLPC_CTL_PD_REQ]) begin
                    pd_state_next = shift_reg[`SLPC_CTL_PD_SYNC] ? PD_WAIT : PD_DOWN;
                end
            end
            PD_WAIT: begin
                if (!pd_req) begin
                    pd_state_next = PD_ON;
                end else if (!pd_sync) begin
                    pd_state_next = PD_DOWN;
                end else if (refo_rise && edge_cnt_reg == `SLPC_SYNC_PD_EDGES - 2'h1) begin
                    pd_state_next = PD_DOWN;
                end
            end
            PD_DOWN: begin
                // Leaving keeps latches, so band is kept
                if (!pd_req) begin
                    pd_state_next = PD_ON;
                end
            end
            default: begin
                pd_state_next = PD_ON;
            end
        endcase
    end

    // State and reference edge count; count restarts on each strobe rise
    always @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            pd_state_reg <= PD_ON;
            edge_cnt_reg <= 2'h0;
        end else begin
            pd_state_reg <= pd_state_next;
            if (strobe_rise || pd_state_reg != PD_WAIT) begin
                edge_cnt_reg <= 2'h0;
            end else if (refo_rise) begin
                edge_cnt_reg <= edge_cnt_reg + 2'h1;
            end
        end
    end

    // Chip enable does not touch latches
    assign down = (pd_state_next == PD_DOWN) | ~ce_s;

    // Registered outputs; power-down effects follow the combined state
    always @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            prescale_sel_o <= 2'h0;
            main_count_o <= 13'h0000;
            swallow_count_o <= 5'h00;
            ref_div_o <= 14'h0000;
            pump_gain_bit_o <= 1'b0;
            powered_down_o <= 1'b1;
            counters_load_o <= 1'b1;
            pump_tristate_o <= 1'b1;
            lock_detect_reset_o <= 1'b1;
            rf_debias_o <= 1'b1;
            ref_buffer_off_o <= 1'b1;
            dc_paths_off_o <= 1'b1;
        end else begin
            prescale_sel_o <= control_latch_o[`SLPC_CTL_PRESCALE_HI:`SLPC_CTL_PRESCALE_LO];
            main_count_o <= fb_latch_o[`SLPC_FB_MAIN_HI:`SLPC_FB_MAIN_LO];
            swallow_count_o <= fb_latch_o[`SLPC_FB_SWALLOW_HI:`SLPC_FB_SWALLOW_LO];
            ref_div_o <= ref_latch_o[`SLPC_REF_DIV_HI:`SLPC_REF_DIV_LO];
            pump_gain_bit_o <= pump_gain_reg;
            powered_down_o <= down;
            // Counters load, pump off, lock reset
            // Divider reset bit also holds counters
            counters_load_o <= down | control_latch_o[`SLPC_CTL_DIV_RESET];
            pump_tristate_o <= down | control_latch_o[`SLPC_CTL_PUMP_TRISTATE];
            lock_detect_reset_o <= down;
            // Outputs debiased, buffer and DC paths off
            rf_debias_o <= down;
            ref_buffer_off_o <= down;
            dc_paths_off_o <= down;
        end
    end
endmodule // slpc_top
`default_nettype wire

// ### hw/slpc_consts.vh
// Constants for the synthesizer latch and power-down controller.
// Included by hw/slpc_top.v; definitions only.
`ifndef SLPC_CONSTS_VH
`define SLPC_CONSTS_VH
// Serial word
`define SLPC_WORD_W 24
// Latch select codes (select_high, select_low)
`define SLPC_SEL_CONTROL 2'h0
`define SLPC_SEL_REFDIV 2'h1
`define SLPC_SEL_FBDIV 2'h2
`define SLPC_SEL_TEST 2'h3
// Control latch fields
`define SLPC_CTL_PRESCALE_HI 23
`define SLPC_CTL_PRESCALE_LO 22
`define SLPC_CTL_PD_SYNC 21
`define SLPC_CTL_PD_REQ 20
`define SLPC_CTL_PUMP_GAIN 10
`define SLPC_CTL_PUMP_TRISTATE 9
`define SLPC_CTL_DIV_RESET 4
// Feedback divider latch fields
`define SLPC_FB_PUMP_GAIN 21
`define SLPC_FB_MAIN_HI 20
`define SLPC_FB_MAIN_LO 8
`define SLPC_FB_SWALLOW_HI 6
`define SLPC_FB_SWALLOW_LO 2
// Reference divider latch fields
`define SLPC_REF_DIV_HI 15
`define SLPC_REF_DIV_LO 2
// Reset values
`define SLPC_LATCH_RESET 24'h000000
// Synchronous power-down waits this many reference-divider rising edges
`define SLPC_SYNC_PD_EDGES 2'h2
`endif

// ### hw/slpc_sync3.v
// Three-flop synchroniser with agreement filter for one pin.
// Assumes the pin is asynchronous to clk_i; output changes when stage 2 and 3 agree.
`timescale 1ns/100ps
`default_nettype none
module slpc_sync3 (
    input wire clk_i,   // Sampling clock
    input wire rstn_i,  // Synchronous reset, active low
    input wire pin_i,   // Asynchronous pin
    output reg level_o  // Filtered level
);
    reg s1_reg;
    reg s2_reg;
    reg s3_reg;

    // Stage 1 feeds only stage 2 to keep metastability contained
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            level_o <= 1'b0;
        end else begin
            s1_reg <= pin_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                level_o <= s3_reg;
            end
        end
    end
endmodule // slpc_sync3
`default_nettype wire

// ### dv/slpc_sva.sv
// Port checker for slpc_top.
// Assumes a bind onto slpc_top; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module slpc_sva (
    input wire logic ref_clk_i, // Clock
    input wire logic rstn_i, // Reset
    input wire logic chip_enable_i, // Enable pin
    input wire logic [23:0] control_latch_o, // Control
    input wire logic [23:0] fb_latch_o, // Feedback
    input wire logic [1:0] prescale_sel_o, // Prescale
    input wire logic [12:0] main_count_o, // Main
    input wire logic [4:0] swallow_count_o, // Swallow
    input wire logic pump_gain_bit_o, // Gain
    input wire logic powered_down_o, // Down
    input wire logic counters_load_o, // Load
    input wire logic pump_tristate_o, // Pump off
    input wire logic lock_detect_reset_o, // Lock reset
    input wire logic rf_debias_o, // Debias
    input wire logic ref_buffer_off_o, // Buffer off
    input wire logic dc_paths_off_o // DC off
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    // Fields trail their latch by one edge
    a_prescale_field: assert property (prescale_sel_o == $past(control_latch_o[23:22])) else $error("prescale");
    a_fb_fields: assert property (
        {main_count_o, swallow_count_o} == $past({fb_latch_o[20:8], fb_latch_o[6:2]})) else $error("fb fields");
    a_pd_effects: assert property (
        {lock_detect_reset_o, rf_debias_o, ref_buffer_off_o, dc_paths_off_o} == {4{powered_down_o}}) else $error("fx");
    a_pd_forces: assert property (powered_down_o |-> counters_load_o && pump_tristate_o) else $error("forces");
    // Async request lands with the latch transfer
    a_async_pd: assert property (
        $changed(control_latch_o) && control_latch_o[21:20] == 2'h1 |-> ##[0:1] powered_down_o) else $error("async");
    // Synchroniser delay is about five edges, so eight is safe
    a_ce_forces: assert property (!chip_enable_i [*8] |-> powered_down_o) else $error("ce");
    a_pd_release: assert property ($fell(powered_down_o) |-> !control_latch_o[20]) else $error("release");
    a_gain_ctl: assert property (
        $changed(control_latch_o) |=> pump_gain_bit_o == $past(control_latch_o[10])) else $error("gain");
endmodule // slpc_sva
bind slpc_top slpc_sva slpc_sva_inst (.*);
`default_nettype wire

// ### dv/slpc_host.sv
// Host model driving the 3-wire serial port.
// Assumes ref_clk_i is the bench clock; serial clock stands low between words.
`timescale 1ns/100ps
`default_nettype none
module slpc_host (
    input wire logic ref_clk_i, // Bench clock
    output var logic sclk_o, // Serial clock
    output var logic sdata_o, // Serial data
    output var logic strobe_o // Load strobe
);
    initial begin
        sclk_o = 1'b0;
        sdata_o = 1'b0;
        strobe_o = 1'b0;
    end
    // MSB first, 64 ns period, strobe rise after last bit
    task automatic send_word(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            sdata_o <= w[i];
            repeat (4) @(posedge ref_clk_i);
            sclk_o <= 1'b1;
            repeat (4) @(posedge ref_clk_i);
            sclk_o <= 1'b0;
        end
        repeat (6) @(posedge ref_clk_i);
        strobe_o <= 1'b1;
        sdata_o <= ~w[0]; // Released line must not keep its last bit
        repeat (4) @(posedge ref_clk_i);
        strobe_o <= 1'b0;
    endtask
endmodule // slpc_host
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench for slpc_top driven by the host model.
// Assumes hw/ and dv/ files compile together.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic ref_clk_i, rstn_i, chip_enable_i, ref_div_out_i, serial_clk_i, serial_data_i, latch_load_strobe_i;
    logic [23:0] control_latch_o, fb_latch_o, ref_latch_o;
    logic [1:0] prescale_sel_o;
    logic [12:0] main_count_o;
    logic [4:0] swallow_count_o;
    logic [13:0] ref_div_o;
    logic pump_gain_bit_o, powered_down_o, counters_load_o, pump_tristate_o;
    logic lock_detect_reset_o, rf_debias_o, ref_buffer_off_o, dc_paths_off_o;
    integer fails, comparisons;
    slpc_host slpc_host_inst (.ref_clk_i(ref_clk_i), .sclk_o(serial_clk_i), .sdata_o(serial_data_i),
        .strobe_o(latch_load_strobe_i));
    slpc_top slpc_top_inst (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .serial_clk_i(serial_clk_i),
        .serial_data_i(serial_data_i),
        .latch_load_strobe_i(latch_load_strobe_i),
        .chip_enable_i(chip_enable_i),
        .ref_div_out_i(ref_div_out_i),
        .control_latch_o(control_latch_o),
        .fb_latch_o(fb_latch_o),
        .ref_latch_o(ref_latch_o),
        .prescale_sel_o(prescale_sel_o),
        .main_count_o(main_count_o),
        .swallow_count_o(swallow_count_o),
        .ref_div_o(ref_div_o),
        .pump_gain_bit_o(pump_gain_bit_o),
        .powered_down_o(powered_down_o),
        .counters_load_o(counters_load_o),
        .pump_tristate_o(pump_tristate_o),
        .lock_detect_reset_o(lock_detect_reset_o),
        .rf_debias_o(rf_debias_o),
        .ref_buffer_off_o(ref_buffer_off_o),
        .dc_paths_off_o(dc_paths_off_o)
    );
    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic results;
        $display("Comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Transfer lands about five edges after the strobe rise
    task automatic put(input logic [23:0] w);
        slpc_host_inst.send_word(w);
        repeat (8) @(posedge ref_clk_i);
    endtask
    task automatic t_select;
        put(24'h00FFFD);
        put(24'h8001A0);
        repeat (75000) @(posedge ref_clk_i);
        put(24'h1FFF56);
        put(24'hFFFFFF); // Test-latch code is dropped
        check("ref", ref_latch_o, 24'h00FFFD);
        check("ratio", 24'(ref_div_o), 24'h003FFF);
        check("ctl", control_latch_o, 24'h8001A0);
        check("fields", {prescale_sel_o, main_count_o, swallow_count_o, 4'h0}, 24'hBFFF50);
    endtask
    task automatic t_gain;
        put(24'h8005B0);
        check("gain ctl", 24'({pump_gain_bit_o, counters_load_o}), 24'h3);
        put(24'h000102);
        check("gain fb", 24'(pump_gain_bit_o), 24'h0);
    endtask
    task automatic t_async;
        put(24'h9001A0);
        check("pd fx", 24'({powered_down_o, counters_load_o, pump_tristate_o, lock_detect_reset_o,
            rf_debias_o, ref_buffer_off_o, dc_paths_off_o}), 24'h7F);
        check("fb kept", fb_latch_o, 24'h000102);
        put(24'h000011);
        check("ref in pd", ref_latch_o, 24'h000011);
        put(24'h8001A0);
        check("pd off", 24'({powered_down_o, counters_load_o, rf_debias_o}), 24'h0);
        check("fb after", fb_latch_o, 24'h000102);
    endtask
    // Power-down only on the second reference rise
    task automatic t_sync;
        put(24'hB001A0);
        check("sync wait", 24'(powered_down_o), 24'h0);
        for (int i = 0; i < 2; i++) begin
            ref_div_out_i <= 1'b1;
            repeat (8) @(posedge ref_clk_i);
            ref_div_out_i <= 1'b0;
            repeat (8) @(posedge ref_clk_i);
            check("sync rise", 24'(powered_down_o), 24'(i));
        end
        put(24'h8001A0);
    endtask
    task automatic t_ce;
        chip_enable_i <= 1'b0;
        repeat (10) @(posedge ref_clk_i);
        check("ce low", 24'(powered_down_o), 24'h1);
        chip_enable_i <= 1'b1;
        repeat (10) @(posedge ref_clk_i);
        check("ce high", 24'(powered_down_o), 24'h0);
        check("fb ce", fb_latch_o, 24'h000102);
    endtask
    initial begin
        rstn_i = 1'b0;
        chip_enable_i = 1'b1;
        ref_div_out_i = 1'b0;
        fails = 0;
        comparisons = 0;
        repeat (8) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        repeat (8) @(posedge ref_clk_i);
        t_select();
        t_gain();
        t_async();
        t_sync();
        t_ce();
        results();
    end
    // Watchdog past the settle gap plus a few thousand cycles of traffic
    initial begin
        repeat (90000) @(posedge ref_clk_i);
        fails = fails + 1;
        results();
    end
endmodule // tb_top
`default_nettype wire
